/* pswin_pkg.sv */
// Purpose: Constants and types for the program space data window.
// Assumes: 100 MHz core_clk, APB register access, 16-bit data space.
// Notes: Function
// Function
// - Upper 32 Kbytes of data space can show any 32K-word program page.
// - Redirect only when address bit 15 is one and enable bit 2 is set.
// - Eight-bit page register picks one of 256 program pages.
// - Program address is page in upper 8 bits, address bits 14:0 below.
// - Low 15 data address bits pass to program address unshifted.
// - Each data address from 8000h maps to one program address.
// - A window read fetches program memory once; its extra cycles depend on its class.
// - A window read returns only the low 16 bits of the 24-bit word.
// - Window redirection is suspended while a table read or write runs.
// - Outside repeat, single and double move reads through window add one cycle.
// - Outside repeat, other window reads add two cycles; window writes add none.
// - In repeat, first, last, interrupt exit and resume read iterations add two.
// - Other repeat iterations through the window finish in one cycle.
package pswin_pkg;

  localparam int          DATA_W        = 16;
  localparam int          PAGE_W        = 8;
  localparam int          WIN_LO_W      = 15;
  localparam int          PM_ADDR_W     = PAGE_W + WIN_LO_W;
  localparam int          PM_WORD_W     = 24;

  // APB map, byte addresses
  localparam logic [7:0]  OFS_PAGE      = 8'h00;
  localparam logic [7:0]  OFS_CORE_CTRL = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;

  localparam int          CCR_EN_BIT    = 2;
  localparam logic [7:0]  PAGE_RST      = 8'h00;
  localparam logic        CCR_EN_RST    = 1'b0;
  localparam int          STS_BUSY_BIT  = 0;
  localparam int          STS_LASTW_BIT = 1;
  localparam int          STS_CNT_LSB   = 16;

  // Added cycles per access class
  localparam logic [1:0]  EXTRA_MOVE     = 2'h1;
  localparam logic [1:0]  EXTRA_OTHER    = 2'h2;
  localparam logic [1:0]  EXTRA_REP_EDGE = 2'h2;
  localparam logic [1:0]  EXTRA_REP_MID  = 2'h0;
  localparam logic [1:0]  EXTRA_NONE     = 2'h0;

  typedef struct packed {
    logic              we;
    logic [DATA_W-1:0] ea;
    logic [DATA_W-1:0] wdata;
    logic              is_move;
    logic              in_repeat;
    logic              repeat_edge;
  } pswin_req_t;

  typedef struct packed {
    logic              we;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pswin_dm_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACCESS = 3'b010,
    ST_EXTRA  = 3'b100
  } pswin_state_t;

endpackage

/* pswin_top.sv */
// Purpose: Maps the upper half of data space onto a program memory page.
// Assumes: Program and data memories answer in the cycle of their request.
// Notes: One request at a time; requests while busy are ignored.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pswin_top
  import pswin_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Core data-space access
  input  wire logic                 cpu_req_valid,
  input  wire pswin_req_t           cpu_req,
  input  wire logic                 table_active,
  output logic                      cpu_busy,
  output logic                      cpu_ack,
  output logic      [DATA_W-1:0]    cpu_rdata,
  // Program memory
  output logic                      pm_req,
  output logic      [PM_ADDR_W-1:0] pm_addr,
  input  wire logic [PM_WORD_W-1:0] pm_rdata,
  // Data memory
  output logic                      dm_req,
  output pswin_dm_t                 dm_cmd,
  input  wire logic [DATA_W-1:0]    dm_rdata
);

  function automatic logic [1:0] pswin_extra(input pswin_req_t r);
    if (!r.in_repeat) begin
      return r.is_move ? EXTRA_MOVE : EXTRA_OTHER;
    end
    return r.repeat_edge ? EXTRA_REP_EDGE : EXTRA_REP_MID;
  endfunction

  logic [PAGE_W-1:0]  page_reg;
  logic               ccr_en_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  pswin_state_t       state_reg;
  pswin_req_t         req_reg;
  logic [1:0]         extra_reg;
  logic               busy_reg;
  logic               ack_reg;
  logic [DATA_W-1:0]  rdata_reg;
  logic               pm_req_reg;
  logic [PM_ADDR_W-1:0] pm_addr_reg;
  logic               dm_req_reg;
  pswin_dm_t          dm_reg;
  logic               last_win_reg;
  logic [15:0]        win_cnt_reg;
  logic               accept;
  logic               hit;
  logic               apb_wr;
  logic               apb_setup_acc;
  logic               addr_ok;

  assign accept        = cpu_req_valid && (state_reg == ST_IDLE);
  // Table operations own program memory, so the window steps aside
  assign hit           = cpu_req.ea[DATA_W-1] && ccr_en_reg
                         && !table_active;
  assign apb_setup_acc = psel && penable && !pready_reg;
  assign apb_wr        = psel && penable && pready_reg && pwrite;
  assign addr_ok       = (paddr == OFS_PAGE) || (paddr == OFS_CORE_CTRL)
                         || (paddr == OFS_STATUS);

  // APB: one wait state, so every output stays a flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (apb_setup_acc) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !addr_ok;
      prdata_reg  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          OFS_PAGE:      prdata_reg[PAGE_W-1:0] <= page_reg;
          OFS_CORE_CTRL: prdata_reg[CCR_EN_BIT] <= ccr_en_reg;
          OFS_STATUS: begin
            prdata_reg[STS_BUSY_BIT]  <= busy_reg;
            prdata_reg[STS_LASTW_BIT] <= last_win_reg;
            prdata_reg[31:STS_CNT_LSB] <= win_cnt_reg;
          end
          default:       prdata_reg <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Window control registers, written at the completing APB edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_reg   <= PAGE_RST;
      ccr_en_reg <= CCR_EN_RST;
    end else if (apb_wr) begin
      if (paddr == OFS_PAGE) begin
        page_reg <= pwdata[PAGE_W-1:0];
      end
      if (paddr == OFS_CORE_CTRL) begin
        ccr_en_reg <= pwdata[CCR_EN_BIT];
      end
    end
  end

  // Access sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      req_reg   <= '0;
      extra_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cpu_req_valid) begin
            req_reg   <= cpu_req;
            // Extra cycles only for window reads
            extra_reg <= (hit && !cpu_req.we) ? pswin_extra(cpu_req)
                                              : EXTRA_NONE;
            state_reg <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          state_reg <= (extra_reg == EXTRA_NONE) ? ST_IDLE
                                                 : ST_EXTRA;
        end
        ST_EXTRA: begin
          extra_reg <= extra_reg - 2'h1;
          if (extra_reg == 2'h1) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Memory requests, one cycle each
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pm_req_reg  <= 1'b0;
      pm_addr_reg <= '0;
      dm_req_reg  <= 1'b0;
      dm_reg      <= '0;
    end else begin
      pm_req_reg <= accept && hit && !cpu_req.we;
      dm_req_reg <= accept && !hit;
      if (accept && hit) begin
        // Low word address bits are the data address bits themselves, no shift
        pm_addr_reg <= {page_reg, cpu_req.ea[WIN_LO_W-1:0]};
      end
      if (accept && !hit) begin
        dm_reg.we    <= cpu_req.we;
        dm_reg.addr  <= cpu_req.ea;
        dm_reg.wdata <= cpu_req.wdata;
      end
    end
  end

  // Answer to the core
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
      busy_reg  <= 1'b0;
    end else begin
      ack_reg <= ((state_reg == ST_ACCESS) && (extra_reg == EXTRA_NONE))
                 || ((state_reg == ST_EXTRA) && (extra_reg == 2'h1));
      if (state_reg == ST_ACCESS) begin
        if (pm_req_reg) begin
          // Upper byte of the program word is dropped
          rdata_reg <= pm_rdata[DATA_W-1:0];
        end else if (dm_req_reg && !dm_reg.we) begin
          rdata_reg <= dm_rdata;
        end else begin
          rdata_reg <= '0;
        end
      end
      if (accept) begin
        busy_reg <= 1'b1;
      end else if (((state_reg == ST_ACCESS) && (extra_reg == EXTRA_NONE))
                   || ((state_reg == ST_EXTRA) && (extra_reg == 2'h1))) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Status bookkeeping
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_win_reg <= 1'b0;
      win_cnt_reg  <= 16'h0000;
    end else begin
      if (accept) begin
        last_win_reg <= hit;
      end
      if (pm_req_reg) begin
        win_cnt_reg <= win_cnt_reg + 16'h0001;
      end
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign cpu_busy  = busy_reg;
  assign cpu_ack   = ack_reg;
  assign cpu_rdata = rdata_reg;
  assign pm_req    = pm_req_reg;
  assign pm_addr   = pm_addr_reg;
  assign dm_req    = dm_req_reg;
  assign dm_cmd    = dm_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic acc_wrd;
  logic acc_rep_mid;
  assign acc_wrd     = accept && hit && !cpu_req.we;
  assign acc_rep_mid = acc_wrd && cpu_req.in_repeat && !cpu_req.repeat_edge;

  AST_PAGE_WRITE: assert property (
    apb_wr && (paddr == OFS_PAGE) |=> page_reg == $past(pwdata[7:0]))
    else $error("page register did not take written value");

  AST_WIN_ROUTE: assert property (
    acc_wrd |=> pm_req && !dm_req)
    else $error("window read not sent to program memory");

  AST_WIN_ADDR: assert property (
    acc_wrd |=> pm_addr == {$past(page_reg), $past(cpu_req.ea[14:0])})
    else $error("program address not page plus low address bits");

  AST_LOW_BITS: assert property (
    pm_req |-> pm_addr[14:0] == req_reg.ea[14:0])
    else $error("low address bits shifted");

  AST_WIN_DATA: assert property (
    pm_req |=> cpu_rdata == $past(pm_rdata[15:0]))
    else $error("window read data not low 16 bits");

  AST_TABLE_OFF: assert property (
    accept && table_active |=> !pm_req && dm_req)
    else $error("window active during table operation");

  AST_MOVE_EXTRA: assert property (
    acc_wrd && !cpu_req.in_repeat && cpu_req.is_move
    |=> !cpu_ack ##1 !cpu_ack ##1 cpu_ack)
    else $error("move through window not one extra cycle");

  AST_OTHER_EXTRA: assert property (
    acc_wrd && !cpu_req.in_repeat && !cpu_req.is_move
    |=> !cpu_ack [*3] ##1 cpu_ack)
    else $error("other window access not two extra cycles");

  AST_REP_EDGE: assert property (
    acc_wrd && cpu_req.in_repeat && cpu_req.repeat_edge
    |=> !cpu_ack [*3] ##1 cpu_ack)
    else $error("repeat edge iteration not two extra cycles");

  AST_REP_MID: assert property (
    acc_rep_mid |=> !cpu_ack ##1 cpu_ack)
    else $error("repeat middle iteration not single cycle");

  AST_PLAIN: assert property (
    accept && !hit |=> dm_req && !pm_req ##1 cpu_ack)
    else $error("plain access delayed or misrouted");

  // Registers move only on their own completing write
  AST_PAGE_HOLD: assert property (
    !(apb_wr && (paddr == OFS_PAGE)) |=> $stable(page_reg))
    else $error("page register changed without a write");

  AST_EN_HOLD: assert property (
    !(apb_wr && (paddr == OFS_CORE_CTRL)) |=> $stable(ccr_en_reg))
    else $error("window enable changed without a write");

  AST_ONE_MEMORY: assert property (
    pm_req |-> !dm_req)
    else $error("program and data memory requested together");

  AST_WIN_WRITE: assert property (
    accept && hit && cpu_req.we |=> !pm_req && !dm_req ##1 cpu_ack)
    else $error("window write not acked without extra cycles");

  COV_WIN_READ: cover property (acc_wrd ##[1:4] cpu_ack);
  COV_REP_MID: cover property (acc_rep_mid ##2 cpu_ack);
  COV_TABLE: cover property (accept && table_active && cpu_req.ea[15]);
  COV_APB_ERR: cover property (pslverr && pready);
  COV_WIN_WRITE: cover property (accept && hit && cpu_req.we);

endmodule

/* pswin_mem_model.sv */
// Purpose: Program and data memory seen from the window block.
// Assumes: Both memories answer in the cycle of their request.
// Notes: Idle read buses show inverted data so stale values never match.
`timescale 1ns/1ps
module pswin_mem_model
  import pswin_pkg::*;
(
  // Clock
  input  wire logic                 core_clk,
  // Program memory
  input  wire logic                 pm_req,
  input  wire logic [PM_ADDR_W-1:0] pm_addr,
  output logic      [PM_WORD_W-1:0] pm_rdata,
  // Data memory
  input  wire logic                 dm_req,
  input  wire pswin_dm_t            dm_cmd,
  output logic      [DATA_W-1:0]    dm_rdata
);
  logic [DATA_W-1:0]    dmem [256];
  logic [PM_WORD_W-1:0] pm_last;
  logic [DATA_W-1:0]    dm_last;
  logic [PM_WORD_W-1:0] pm_word;

  initial begin
    pm_last = 24'h000000;
    dm_last = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      dmem[i] = 16'h0000;
    end
  end

  // Upper byte all ones so stray execution stays harmless
  assign pm_word = {8'hff, pm_addr[22:7] ^ pm_addr[15:0]};
  assign pm_rdata = pm_req ? pm_word : ~pm_last;
  assign dm_rdata = dm_req ? dmem[dm_cmd.addr[7:0]] : ~dm_last;

  always @(posedge core_clk) begin
    if (pm_req) begin
      pm_last <= pm_word;
    end
    if (dm_req) begin
      dm_last <= dm_rdata;
    end
    if (dm_req && dm_cmd.we) begin
      dmem[dm_cmd.addr[7:0]] <= dm_cmd.wdata;
    end
  end
endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the program space data window.
// Assumes: Memory model answers in the cycle of each request.
// Notes: Latency is counted in edges from the accepting edge through the ack edge.
`timescale 1ns/1ps
module tb_top
  import pswin_pkg::*;
;
  logic                 core_clk = 1'b0;
  logic                 arst_n = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 cpu_req_valid = 1'b0;
  logic                 table_active = 1'b0;
  pswin_req_t           cpu_req = '0;
  logic                 cpu_busy;
  logic                 cpu_ack;
  logic [DATA_W-1:0]    cpu_rdata;
  logic                 pm_req;
  logic [PM_ADDR_W-1:0] pm_addr;
  logic [PM_WORD_W-1:0] pm_rdata;
  logic                 dm_req;
  pswin_dm_t            dm_cmd;
  logic [DATA_W-1:0]    dm_rdata;
  int                   error_cnt = 0;
  int                   cmp_count = 0;
  logic [31:0]          rd;
  logic                 err;
  logic [7:0]           pg = 8'h00;

  always #5 core_clk = ~core_clk;

  pswin_top pswin_top_i (.core_clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_req_valid, .cpu_req,
    .table_active, .cpu_busy, .cpu_ack, .cpu_rdata, .pm_req, .pm_addr,
    .pm_rdata, .dm_req, .dm_cmd, .dm_rdata);

  pswin_mem_model pswin_mem_model_i (.core_clk, .pm_req, .pm_addr,
    .pm_rdata, .dm_req, .dm_cmd, .dm_rdata);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setpg(input logic [7:0] p);
    apb(1'b1, OFS_PAGE, {24'h0, p});
    pg = p;
  endtask

  // Path: 2'b10 program memory, 2'b01 data memory, 2'b00 none
  task automatic core(input logic we, input logic [15:0] ea, wd,
                      input logic mv, rp, edg, input int lat,
                      input logic [1:0] path);
    int n;
    logic sp, sd;
    logic [22:0] pa, full;
    logic [15:0] da;
    n = 1;
    sp = 1'b0;
    sd = 1'b0;
    full = {pg, ea[14:0]};
    @(posedge core_clk);
    cpu_req_valid <= 1'b1;
    cpu_req <= {we, ea, wd, mv, rp, edg};
    @(posedge core_clk);
    cpu_req_valid <= 1'b0;
    #1;
    chk(cpu_busy, 1);
    while (cpu_ack !== 1'b1 && n < 20) begin
      if (pm_req === 1'b1) begin
        sp = 1'b1;
        pa = pm_addr;
      end
      if (dm_req === 1'b1) begin
        sd = 1'b1;
        da = dm_cmd.addr;
      end
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n, lat);
    chk({sp, sd}, path);
    chk(cpu_busy, 0);
    if (sp) chk(pa, full);
    if (sd) chk(da, ea);
    if (!we && sp) chk(cpu_rdata, full[22:7] ^ full[15:0]);
  endtask

  task automatic t_regs;
    apb(1'b0, OFS_PAGE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_CORE_CTRL, 32'h0);
    chk(rd, 32'h0);
    setpg(8'hff);
    apb(1'b1, OFS_PAGE, 32'h1ff);
    apb(1'b0, OFS_PAGE, 32'h0);
    chk(rd, 32'hff);
    apb(1'b1, OFS_CORE_CTRL, 32'hffffffff);
    apb(1'b0, OFS_CORE_CTRL, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, 8'h0c, 32'h1);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_window;
    core(1'b0, 16'hffff, 16'h0, 1'b1, 1'b0, 1'b0, 3, 2'b10);
    setpg(8'h5a);
    core(1'b0, 16'h8000, 16'h0, 1'b0, 1'b0, 1'b0, 4, 2'b10);
    core(1'b1, 16'h8010, 16'hbeef, 1'b1, 1'b0, 1'b0, 2, 2'b00);
    core(1'b0, 16'h8123, 16'h0, 1'b0, 1'b1, 1'b1, 4, 2'b10);
    core(1'b0, 16'h8124, 16'h0, 1'b0, 1'b1, 1'b0, 2, 2'b10);
    // Status: idle, last access hit the window, four window reads
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0004_0002);
    $display("test window done");
  endtask

  task automatic t_bypass;
    @(posedge core_clk);
    table_active <= 1'b1;
    core(1'b1, 16'h9000, 16'h1234, 1'b1, 1'b0, 1'b0, 2, 2'b01);
    core(1'b0, 16'h9000, 16'h0, 1'b1, 1'b0, 1'b0, 2, 2'b01);
    chk(cpu_rdata, 16'h1234);
    @(posedge core_clk);
    table_active <= 1'b0;
    core(1'b0, 16'h0100, 16'h0, 1'b0, 1'b0, 1'b0, 2, 2'b01);
    chk(cpu_rdata, 16'h1234);
    apb(1'b1, OFS_CORE_CTRL, 32'h0);
    core(1'b0, 16'h9000, 16'h0, 1'b0, 1'b0, 1'b0, 2, 2'b01);
    $display("test bypass done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_window();
    t_bypass();
    results();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    results();
  end
endmodule
